/* File: include/uard_consts.svh */
// register map, field positions, reset values and counts of the receiver
`ifndef UARD_CONSTS_SVH
`define UARD_CONSTS_SVH
// register indices; byte address is four times the index
`define UARD_IDX_IRQ_FLAGS   10'h00C
`define UARD_IDX_RX_STATUS   10'h018
`define UARD_IDX_RX_DATA     10'h01A
`define UARD_IDX_IRQ_ENABLES 10'h08C
`define UARD_IDX_TX_STATUS   10'h098
`define UARD_IDX_BAUD_DIV    10'h099
// rx_status_control fields
`define UARD_RC_SERIAL_PORT_ENABLE 7
`define UARD_RC_RX9  6
`define UARD_RC_SINGLE_RECEIVE_ENABLE 5
`define UARD_RC_CONTINUOUS_RECEIVE_ENABLE 4
`define UARD_RC_ADDRESS_DETECT_ENABLE 3
`define UARD_RC_FRAMING_ERROR_FLAG 2
`define UARD_RC_OVERRUN_ERROR_FLAG 1
`define UARD_RC_RECEIVED_NINTH_BIT 0
// tx_status_control fields
`define UARD_TX_CLOCK_SOURCE_SELECT 7
`define UARD_TX_SYNC 4
`define UARD_TX_HIGH_SPEED_BAUD_SELECT 2
`define UARD_TX_SHIFTER_EMPTY_FLAG 1
// irq flag / enable position of the receiver
`define UARD_IRQ_RC  5
// reset values
`define UARD_RST_BYTE   8'h00
`define UARD_RST_TX_STATUS_CONTROL  8'h02
// oversampling counts: sixteen ticks per bit, middle at eight
`define UARD_OVS_LAST   4'hF
`define UARD_OVS_MID    4'h7
`define UARD_BIT_LAST8  4'h7
`define UARD_BIT_LAST9  4'h8
`endif

/* File: include/uard_pkg.sv */
// types shared by the receiver modules
package uard_pkg;
    typedef enum logic [3:0] {
        UARD_IDLE  = 4'h1,
        UARD_START = 4'h2,
        UARD_DATA  = 4'h4,
        UARD_STOP  = 4'h8
    } uard_state_type;
    // fifo entry: framing error, ninth bit, data byte
    typedef struct packed {
        logic       framing_error_flag;
        logic       ninth;
        logic [7:0] data;
    } uard_entry_type;
endpackage

/* File: include/uard_fifo_if.sv */
// carrier between the receiver and its receive buffer
`timescale 1ns/1ps
interface uard_fifo_if;
    import uard_pkg::*;
    logic           push;
    uard_entry_type wdata;
    logic           full;
    logic           pop;
    uard_entry_type rdata;
    logic           empty;
    modport writer (output push, wdata, pop, input full, rdata, empty);
    modport store  (input push, wdata, pop, output full, rdata, empty);
endinterface

/* File: design/uard_fifo.sv */
// receive buffer held in flip-flops
`timescale 1ns/1ps
module uard_fifo #(
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic    clk_sys,
    input wire logic    rst,
    // buffer port
    uard_fifo_if.store  fif
);
    import uard_pkg::*;
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    uard_entry_type   mem [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [CW-1:0]    count_r;
    logic             do_push;
    logic             do_pop;

    assign do_push = fif.push && !fif.full;
    assign do_pop  = fif.pop && !fif.empty;
    assign fif.full  = (count_r == CW'(DEPTH));
    assign fif.empty = (count_r == '0);
    assign fif.rdata = mem[rd_ptr_r];

    // cleared at reset so the buffer reads its documented zeros until the first push
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (do_push) begin
            mem[wr_ptr_r] <= fif.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + CW'(do_push) - CW'(do_pop);
        end
    end
endmodule

/* File: design/uard_baud.sv */
// tick source for oversampling and for the master shift clock
`timescale 1ns/1ps
`include "uard_consts.svh"
module uard_baud (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // configuration
    input  wire logic       run,
    input  wire logic       high_speed,
    input  wire logic       sync_mode,
    input  wire logic [7:0] divisor,
    // one-cycle enable
    output logic            tick
);
    logic [9:0] cnt_r;
    logic [9:0] reload;

    // low speed divides by four more; sync ticks each half shift clock
    always_comb begin
        if (sync_mode) begin
            reload = {1'b0, divisor, 1'b1};
        end else if (high_speed) begin
            reload = {2'b00, divisor};
        end else begin
            reload = {divisor, 2'b11};
        end
    end

    assign tick = run && (cnt_r == '0);

    // held in reset while nothing receives, so the first bit is whole
    always_ff @(posedge clk_sys) begin
        if (rst || !run) begin
            cnt_r <= reload;
        end else if (cnt_r == '0) begin
            cnt_r <= reload;
        end else begin
            cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule

/* File: design/uard_top.sv */
// serial receiver with address detect, wishbone register slave
// Behaviour
// - frames accepted only while continuous receive set, or single receive set in sync mode
// - nine-bit mode stores ninth bit in status
// - address detect needs enable plus nine-bit mode
// - address mode flags only frames with bit8 set
// - data frames dropped under address detect
// - dropped byte overwritten by the next frame
// - address enable ignored outside nine-bit mode
// - without address detect every byte is buffered
// - address detect in async and sync modes
// - receive flag set, request gated by enable
// - sync master is half duplex
// - sync select bit enters synchronous mode
// - port enable turns pins into serial lines
// - clock source select makes device drive clock in sync mode
// - two-entry buffer, flag clears when empty
// - full buffer sets overrun, blocks transfers
// - stop sampled low gives buffered framing error
// - async line oversampled sixteen times per bit
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "uard_consts.svh"
module uard_top #(
    parameter int FIFO_DEPTH = 2
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // wishbone classic slave
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [11:0] wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic             wb_ack,
    // data line, receive only here
    input  wire logic        serial_data_line,
    output logic             serial_data_drive,
    output logic             serial_data_oe_n,
    // shift clock line
    input  wire logic        shift_clock_line,
    output logic             shift_clock_drive,
    output logic             shift_clock_oe_n,
    // transmitter status
    input  wire logic        tx_active,
    input  wire logic        tx_shifter_empty,
    // system
    output logic             serial_pins_enabled,
    output logic             rx_irq_request
);
    import uard_pkg::*;

    uard_fifo_if fif ();

    logic [7:0]     rc_ctrl_r;
    logic           overrun_error_flag_r;
    logic [7:0]     irq_en_r;
    logic [7:0]     tx_ctrl_r;
    logic [7:0]     baud_div_r;
    logic           ack_r;
    logic [31:0]    rdat_r;
    uard_state_type state_r;
    logic [3:0]     ovs_r;
    logic [3:0]     bit_r;
    logic [8:0]     shift_r;
    logic           ck_r;
    logic           ck_prev_r;
    logic           ck_oe_n_r;
    logic           pins_r;
    logic           irq_r;
    logic           tick;
    logic           acc;
    logic           wr;
    logic           rd;
    logic [9:0]     idx;
    logic           hit_rx_status_control;
    logic           hit_rx_data_buffer;
    logic [7:0]     rd_byte;
    logic           serial_port_enable;
    logic           rx9;
    logic           single_receive_enable;
    logic           continuous_receive_enable;
    logic           sync_mode;
    logic           master;
    logic           async_en;
    logic           sync_en;
    logic           rx_run;
    logic           samp;
    logic           last_bit;
    logic           frame_end;
    logic           stop_ok;
    logic           addr_mode;
    logic [7:0]     word;
    logic           ninth;
    logic           keep;
    logic           ovr;
    logic           clr_overrun_error_flag;
    logic           single_receive_enable_done;
    logic [7:0]     rx_status_control_rd;

    // configuration fields
    assign serial_port_enable      = rc_ctrl_r[`UARD_RC_SERIAL_PORT_ENABLE];
    assign rx9       = rc_ctrl_r[`UARD_RC_RX9];
    assign single_receive_enable      = rc_ctrl_r[`UARD_RC_SINGLE_RECEIVE_ENABLE];
    assign continuous_receive_enable      = rc_ctrl_r[`UARD_RC_CONTINUOUS_RECEIVE_ENABLE];
    assign sync_mode = tx_ctrl_r[`UARD_TX_SYNC];
    assign master    = sync_mode && tx_ctrl_r[`UARD_TX_CLOCK_SOURCE_SELECT];
    assign async_en  = serial_port_enable && !sync_mode && continuous_receive_enable;
    assign sync_en   = serial_port_enable && sync_mode && (continuous_receive_enable || single_receive_enable);
    assign rx_run    = async_en || sync_en;
    assign addr_mode = rc_ctrl_r[`UARD_RC_ADDRESS_DETECT_ENABLE] && rx9;

    // divisor and speed select set the tick rate
    uard_baud u_baud (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .run        (rx_run),
        .high_speed (tx_ctrl_r[`UARD_TX_HIGH_SPEED_BAUD_SELECT]),
        .sync_mode  (sync_mode),
        .divisor    (baud_div_r),
        .tick       (tick)
    );

    uard_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys (clk_sys),
        .rst     (rst),
        .fif     (fif.store)
    );

    // bus decode; ack answers every access, unmapped reads give zero
    assign acc = wb_cyc && wb_stb && !ack_r;
    assign wr  = acc && wb_we && wb_sel[0];
    assign rd  = acc && !wb_we;
    assign idx = wb_adr[11:2];
    assign hit_rx_status_control = (idx == `UARD_IDX_RX_STATUS);
    assign hit_rx_data_buffer = (idx == `UARD_IDX_RX_DATA);

    // ninth bit and framing error of the buffer head, overrun flag from its register
    // framing error travels with its byte
    assign rx_status_control_rd = {rc_ctrl_r[7:3], fif.rdata.framing_error_flag, overrun_error_flag_r,
                       fif.rdata.ninth};

    always_comb begin
        rd_byte = `UARD_RST_BYTE;
        if (idx == `UARD_IDX_IRQ_FLAGS) begin
            // receive flag shows a filled buffer
            rd_byte[`UARD_IRQ_RC] = !fif.empty;
        end else if (hit_rx_status_control) begin
            rd_byte = rx_status_control_rd;
        end else if (hit_rx_data_buffer) begin
            rd_byte = fif.rdata.data;
        end else if (idx == `UARD_IDX_IRQ_ENABLES) begin
            rd_byte = irq_en_r;
        end else if (idx == `UARD_IDX_TX_STATUS) begin
            rd_byte = tx_ctrl_r;
            rd_byte[`UARD_TX_SHIFTER_EMPTY_FLAG] = tx_shifter_empty;
        end else if (idx == `UARD_IDX_BAUD_DIV) begin
            rd_byte = baud_div_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_r  <= 1'b0;
            rdat_r <= '0;
        end else begin
            ack_r <= acc;
            if (rd) begin
                rdat_r <= {24'h000000, rd_byte};
            end
        end
    end

    // reading the byte advances flag fields to the next entry
    // flag drops only once the buffer is empty
    assign fif.pop = rd && hit_rx_data_buffer;

    assign clr_overrun_error_flag = wr && hit_rx_status_control && continuous_receive_enable && !wb_dat_w[`UARD_RC_CONTINUOUS_RECEIVE_ENABLE];
    assign single_receive_enable_done = frame_end && sync_mode && single_receive_enable && !continuous_receive_enable;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rc_ctrl_r <= `UARD_RST_BYTE;
        end else if (wr && hit_rx_status_control) begin
            rc_ctrl_r <= {wb_dat_w[7:3], 3'b000};
        end else if (single_receive_enable_done) begin
            // single receive ends after one word
            rc_ctrl_r[`UARD_RC_SINGLE_RECEIVE_ENABLE] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_en_r   <= `UARD_RST_BYTE;
            tx_ctrl_r  <= `UARD_RST_TX_STATUS_CONTROL;
            baud_div_r <= `UARD_RST_BYTE;
        end else if (wr) begin
            if (idx == `UARD_IDX_IRQ_ENABLES) begin
                irq_en_r <= wb_dat_w[7:0];
            end else if (idx == `UARD_IDX_TX_STATUS) begin
                tx_ctrl_r <= wb_dat_w[7:0];
            end else if (idx == `UARD_IDX_BAUD_DIV) begin
                baud_div_r <= wb_dat_w[7:0];
            end
        end
    end

    // sample event: mid bit async, own falling edge as master,
    // falling edge of the far clock as slave
    assign last_bit = (bit_r == (rx9 ? `UARD_BIT_LAST9 : `UARD_BIT_LAST8));
    always_comb begin
        if (!sync_mode) begin
            samp = tick && (ovs_r == `UARD_OVS_LAST);
        end else if (master) begin
            samp = tick && ck_r;
        end else begin
            samp = ck_prev_r && !shift_clock_line;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !rx_run) begin
            // receive logic held in reset while disabled
            state_r <= UARD_IDLE;
            ovs_r   <= '0;
            bit_r   <= '0;
            shift_r <= '0;
            ck_r    <= 1'b0;
        end else begin
            case (state_r)
                UARD_IDLE: begin
                    ovs_r <= '0;
                    bit_r <= '0;
                    ck_r  <= 1'b0;
                    if (sync_mode) begin
                        if (!tx_active) begin
                            state_r <= UARD_DATA;
                        end
                    end else if (tick && !serial_data_line) begin
                        state_r <= UARD_START;
                    end
                end
                UARD_START: begin
                    if (tick) begin
                        ovs_r <= ovs_r + 1'b1;
                        if (ovs_r == `UARD_OVS_MID) begin
                            ovs_r   <= '0;
                            // false start returns to idle
                            state_r <= serial_data_line ? UARD_IDLE
                                                        : UARD_DATA;
                        end
                    end
                end
                UARD_DATA: begin
                    if (tick) begin
                        ovs_r <= ovs_r + 1'b1;
                        if (master) begin
                            ck_r <= !ck_r;
                        end
                    end
                    if (samp) begin
                        // new frame overwrites a dropped byte
                        shift_r <= {serial_data_line, shift_r[8:1]};
                        bit_r   <= bit_r + 1'b1;
                        if (last_bit) begin
                            state_r <= UARD_STOP;
                        end
                    end
                end
                UARD_STOP: begin
                    if (tick) begin
                        ovs_r <= ovs_r + 1'b1;
                    end
                    if (frame_end) begin
                        state_r <= UARD_IDLE;
                    end
                end
                default: begin
                    state_r <= UARD_IDLE;
                end
            endcase
        end
    end

    // sync frames end right after the last bit; async at the stop sample
    assign frame_end = (state_r == UARD_STOP) && rx_run &&
                       (sync_mode || samp);
    // stop sampled low is a framing error
    assign stop_ok = sync_mode || serial_data_line;
    // nine bits in with rx9, ninth kept separately; eight bits otherwise
    assign word  = rx9 ? shift_r[7:0] : shift_r[8:1];
    assign ninth = rx9 && shift_r[8];
    // address frames pass on bit8 only
    // data frames neither buffered nor flagged
    // without address detect all frames pass
    assign keep = !addr_mode || ninth;
    // full buffer at frame end is an overrun, later frames blocked
    assign ovr = frame_end && keep && fif.full && !overrun_error_flag_r;
    assign fif.push  = frame_end && keep && !fif.full && !overrun_error_flag_r;
    assign fif.wdata = '{framing_error_flag: !stop_ok, ninth: ninth, data: word};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            overrun_error_flag_r <= 1'b0;
        end else if (ovr) begin
            overrun_error_flag_r <= 1'b1;
        end else if (clr_overrun_error_flag) begin
            overrun_error_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ck_prev_r <= 1'b0;
        end else begin
            ck_prev_r <= shift_clock_line;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ck_oe_n_r <= 1'b1;
            pins_r    <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            ck_oe_n_r <= !(serial_port_enable && master);
            pins_r    <= serial_port_enable;
            irq_r     <= !fif.empty && irq_en_r[`UARD_IRQ_RC];
        end
    end

    assign wb_ack              = ack_r;
    assign wb_dat_r            = rdat_r;
    assign shift_clock_drive   = ck_r;
    assign shift_clock_oe_n    = ck_oe_n_r;
    assign serial_pins_enabled = pins_r;
    assign rx_irq_request      = irq_r;
    // the transmitter owns the data line drive; released here
    assign serial_data_drive   = ck_prev_r & 1'b0;
    assign serial_data_oe_n    = !ck_prev_r | 1'b1;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_drop;
        frame_end && addr_mode && !ninth && fif.empty;
    endsequence
    sequence s_pass;
        frame_end && keep && fif.empty && !overrun_error_flag_r;
    endsequence

    rx_gate_off_a: assert property (!rx_run |=> state_r == UARD_IDLE)
        else $error("receiver left idle while disabled");
    addr_drop_a: assert property (s_drop |=> fif.empty ##1 fif.empty)
        else $error("data frame buffered under address detect");
    addr_pass_a: assert property (s_pass ##0 addr_mode |=> !fif.empty)
        else $error("address frame not buffered");
    plain_pass_a: assert property (s_pass ##0 !rx9 |=> !fif.empty)
        else $error("frame lost outside nine-bit mode");
    irq_gate_a: assert property (!irq_en_r[`UARD_IRQ_RC] |=> !irq_r)
        else $error("request raised while disabled");
    irq_set_a: assert property
        (!fif.empty && irq_en_r[`UARD_IRQ_RC] |=> irq_r)
        else $error("request missing for filled buffer");
    overrun_a: assert property (ovr |=> overrun_error_flag_r && fif.full)
        else $error("overrun not flagged");
    half_duplex_a: assert property
        (state_r == UARD_IDLE && sync_mode && tx_active
         |=> state_r != UARD_DATA)
        else $error("reception started while transmitting");
    clock_drive_a: assert property
        (serial_port_enable && master ##1 serial_port_enable && master |-> !shift_clock_oe_n)
        else $error("master not driving shift clock");
    pins_on_a: assert property ($rose(serial_port_enable) |=> serial_pins_enabled)
        else $error("pins not claimed by port enable");
endmodule

/* File: tb/uard_line_model.sv */
// far-end asynchronous transmitter driving the receive data line
`timescale 1ns/1ps
module uard_line_model (
    // clock
    input  wire logic clk_sys,
    // serial output, idles high like a pulled-up line
    output logic      line
);
    initial line = 1'b1;
    // start, data lsb first, optional ninth bit, stop; bclk sets the pace
    task automatic send(input logic [8:0] d, input logic nine,
                        input logic stop_ok, input int bclk);
        int i;
        line <= 1'b0;
        repeat (bclk) @(posedge clk_sys);
        for (i = 0; i < (nine ? 9 : 8); i++) begin
            line <= d[i];
            repeat (bclk) @(posedge clk_sys);
        end
        line <= stop_ok;
        // a bad stop is cut short so its tail cannot pass for a start
        repeat (stop_ok ? bclk : bclk * 3 / 4) @(posedge clk_sys);
        line <= 1'b1;
        repeat (bclk) @(posedge clk_sys);
    endtask
endmodule

/* File: tb/usart_rx_address_detect_bench.sv */
// self-checking bench for the address-detect receiver
`timescale 1ns/1ps
module usart_rx_address_detect_bench;
    // divisor 1 with high speed select: two clocks a tick, 32 a bit
    localparam int BCLK = 32;
    logic        clk_sys, rst, wb_cyc, wb_stb, wb_we, wb_ack, rxd;
    logic [11:0] wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    logic        clk_oe_n, pins_en, irq, dt_oe_n, ck_drv;
    int          n_errors, comparisons;
    logic [11:0] adr [6] = '{12'h030, 12'h060, 12'h068, 12'h230,
                             12'h260, 12'h004};
    logic [7:0]  rstv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};

    uard_top i_uard_top (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .serial_data_line(rxd), .serial_data_drive(),
        .serial_data_oe_n(dt_oe_n), .shift_clock_line(1'b0),
        .shift_clock_drive(ck_drv), .shift_clock_oe_n(clk_oe_n),
        .tx_active(1'b0), .tx_shifter_empty(1'b1),
        .serial_pins_enabled(pins_en), .rx_irq_request(irq));
    uard_line_model i_uard_line_model (.clk_sys(clk_sys), .line(rxd));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // classic cycle: hold everything until ack is sampled, then idle a cycle
    task automatic xfer(input logic we, input logic [11:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= a;
        wb_dat_w <= {24'h000000, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1 && n < 100);
        if (n >= 100) n_errors++;
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdchk(input string what, input logic [11:0] a,
                         input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        check(what, rd, {24'h000000, exp});
    endtask
    task automatic frame(input logic [8:0] d, input logic nine,
                         input logic stop_ok);
        i_uard_line_model.send(d, nine, stop_ok, BCLK);
        repeat (4) @(posedge clk_sys);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        {wb_cyc, wb_stb, wb_we} = 3'h0;
        wb_adr = 12'h000;
        wb_sel = 4'hF;
        wb_dat_w = 32'h00000000;
        n_errors = 0;
        comparisons = 0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        foreach (adr[i]) rdchk("reset value", adr[i], rstv[i]);
        check("data drive released", dt_oe_n, 1'b1);
        check("shift clock idle", ck_drv, 1'b0);
        wr(12'h264, 8'h01);
        wr(12'h260, 8'h04);
        wr(12'h060, 8'h80);
        frame(9'h0A5, 1'b0, 1'b1);
        rdchk("flags receive off", 12'h030, 8'h00);
        wr(12'h060, 8'h90);
        frame(9'h05A, 1'b0, 1'b1);
        check("request masked", irq, 1'b0);
        rdchk("flags", 12'h030, 8'h20);
        wr(12'h230, 8'h20);
        check("request", irq, 1'b1);
        rdchk("status", 12'h060, 8'h90);
        rdchk("data", 12'h068, 8'h5A);
        rdchk("flags empty", 12'h030, 8'h00);
        check("request dropped", irq, 1'b0);
        frame(9'h011, 1'b0, 1'b1);
        frame(9'h022, 1'b0, 1'b1);
        frame(9'h033, 1'b0, 1'b1);
        rdchk("overrun", 12'h060, 8'h92);
        rdchk("first", 12'h068, 8'h11);
        rdchk("second", 12'h068, 8'h22);
        rdchk("drained", 12'h030, 8'h00);
        frame(9'h044, 1'b0, 1'b1);
        rdchk("blocked", 12'h030, 8'h00);
        wr(12'h060, 8'h80);
        wr(12'h060, 8'h90);
        rdchk("overrun cleared", 12'h060, 8'h90);
        frame(9'h0C3, 1'b0, 1'b0);
        rdchk("framing status", 12'h060, 8'h94);
        rdchk("framing data", 12'h068, 8'hC3);
        wr(12'h060, 8'hD8);
        frame(9'h033, 1'b1, 1'b1);
        rdchk("data ignored", 12'h030, 8'h00);
        frame(9'h021, 1'b1, 1'b1);
        frame(9'h1A7, 1'b1, 1'b1);
        rdchk("address status", 12'h060, 8'hD9);
        rdchk("address byte", 12'h068, 8'hA7);
        wr(12'h060, 8'hD0);
        frame(9'h012, 1'b1, 1'b1);
        rdchk("parity status", 12'h060, 8'hD0);
        rdchk("parity data", 12'h068, 8'h12);
        wr(12'h060, 8'h98);
        frame(9'h055, 1'b0, 1'b1);
        rdchk("address enable alone", 12'h030, 8'h20);
        rdchk("byte kept", 12'h068, 8'h55);
        wr(12'h060, 8'h80);
        wr(12'h260, 8'h94);
        check("clock driven", clk_oe_n, 1'b0);
        check("pins enabled", pins_en, 1'b1);
        wr(12'h260, 8'h14);
        check("clock released", clk_oe_n, 1'b1);
        wr(12'h060, 8'h00);
        check("pins released", pins_en, 1'b0);
        complete_run();
    end
endmodule
